// >>> completion_stream_pkg.sv
package completion_stream_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DELIVERED_OFFSET = 8'h08;
    localparam int CTRL_ALIGNED_BIT = 0;
    localparam int CTRL_STRADDLE_BIT = 1;
    localparam logic CTRL_ALIGNED_RESET = 1'h0;
    localparam logic CTRL_STRADDLE_RESET = 1'h0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_COUNT_POS = 8;

    // ----------------------------------------
    // stream layout
    // ----------------------------------------
    localparam int DESC_DWORDS = 3;
    localparam int STRADDLE_LANE = 4;
    localparam int STRADDLE_LANES = 8;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] be;
        logic kp;
        logic sof;
        logic eof;
    } lane_type;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_OFS = 2'b01,
        S_PAY = 2'b10,
        S_PAD = 2'b11
    } fsm_type;

endpackage

// >>> completion_stream_delivery.sv
`timescale 1ns/1ns
module completion_stream_delivery
    import completion_stream_pkg::*;
#(
    parameter int LANES = 8
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire logic [95:0] hdr_desc,
    input wire logic [10:0] hdr_dword_count,
    input wire logic [3:0] hdr_first_be,
    input wire logic [3:0] hdr_last_be,
    input wire logic [2:0] hdr_addr_offset,
    input wire logic hdr_zero_len,
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [LANES*32-1:0] pay_data,
    output logic completion_stream_valid,
    input wire logic completion_stream_accept,
    output logic [LANES*32-1:0] completion_stream_data,
    output logic [LANES-1:0] completion_dword_keep,
    output logic completion_packet_last,
    output logic [LANES*4-1:0] completion_byte_enable,
    output logic first_packet_start_flag,
    output logic second_packet_start_flag,
    output logic [3:0] first_packet_end_field,
    output logic [3:0] second_packet_end_field
);

    localparam int CW = $clog2(2 * LANES) + 1;

    if (!(LANES == 4 || LANES == 8))
    begin : g_check
        $error("LANES must be 4 or 8");
    end

    typedef struct packed {
        fsm_type st;
        lane_type [2*LANES-1:0] lanes;
        logic [CW-1:0] count;
        logic aligned;
        logic strad;
        logic [2:0] offset;
        logic [10:0] total;
        logic [10:0] rem;
        logic [10:0] idx;
        logic [3:0] first_be;
        logic [3:0] last_be;
        logic zero;
        logic ctrl_aligned;
        logic ctrl_strad;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] delivered;
    } state_type;

    state_type q;
    state_type d;

    // ----------------------------------------
    // payload byte enables
    // ----------------------------------------
    function automatic logic [3:0] dword_be(input logic [10:0] j, input logic [10:0] total,
                                            input logic [3:0] first, input logic [3:0] last,
                                            input logic zero);
        logic [3:0] be;
        be = zero ? 4'h0 : 4'hF;
        be = (j == 11'h000) ? (be & first) : be;
        be = (j == total - 11'h001) ? (be & last) : be;
        return be;
    endfunction

    // ----------------------------------------
    // packing and register access
    // ----------------------------------------
    always_comb
    begin
        lane_type [LANES-1:0] src;
        int n;
        int c1;
        int p;
        int ndone;
        logic room;
        logic pop;
        src = '0;
        n = 0;
        ndone = 0;
        d = q;
        hdr_ready = 1'b0;
        pay_ready = 1'b0;
        pop = (int'(q.count) >= LANES) && completion_stream_accept;
        c1 = int'(q.count) - (pop ? LANES : 0);
        if (pop)
        begin
            for (int i = 0; i < 2 * LANES; i++)
            begin
                d.lanes[i] = (i + LANES < 2 * LANES) ? q.lanes[i+LANES] : '0;
            end
            for (int i = 0; i < LANES; i++)
            begin
                ndone = ndone + int'(q.lanes[i].eof);
            end
            d.delivered = q.delivered + 32'(ndone);
        end
        p = c1 % LANES;
        room = (c1 <= LANES);
        unique case (q.st)
            S_IDLE:
            begin
                if (p != 0 && !hdr_valid)
                begin
                    n = LANES - p;
                    for (int i = 0; i < LANES; i++)
                    begin
                        src[i].kp = 1'b1;
                    end
                end
                else
                begin
                    hdr_ready = room;
                    if (hdr_valid && room)
                    begin
                        d.aligned = q.ctrl_aligned;
                        d.strad = q.ctrl_strad && !q.ctrl_aligned && (LANES == STRADDLE_LANES);
                        d.offset = hdr_addr_offset;
                        d.total = hdr_dword_count;
                        d.rem = hdr_dword_count;
                        d.idx = 11'h000;
                        d.first_be = hdr_first_be;
                        d.last_be = hdr_last_be;
                        d.zero = hdr_zero_len;
                        for (int i = 0; i < DESC_DWORDS; i++)
                        begin
                            src[i].data = hdr_desc[i*32+:32];
                            src[i].kp = 1'b1;
                        end
                        src[0].sof = 1'b1;
                        n = DESC_DWORDS;
                        if (hdr_dword_count == 11'h000)
                        begin
                            src[DESC_DWORDS-1].eof = 1'b1;
                            d.st = S_PAD;
                        end
                        else if (q.ctrl_aligned)
                        begin
                            n = LANES;
                            for (int i = DESC_DWORDS; i < LANES; i++)
                            begin
                                src[i].kp = 1'b1;
                            end
                            d.st = (int'(hdr_addr_offset) % LANES != 0) ? S_OFS : S_PAY;
                        end
                        else
                        begin
                            d.st = S_PAY;
                        end
                    end
                end
            end
            S_OFS:
            begin
                if (room)
                begin
                    n = int'(q.offset) % LANES;
                    for (int i = 0; i < LANES; i++)
                    begin
                        src[i].kp = 1'b1;
                    end
                    d.st = S_PAY;
                end
            end
            S_PAY:
            begin
                pay_ready = room;
                if (pay_valid && room)
                begin
                    n = (int'(q.rem) < LANES) ? int'(q.rem) : LANES;
                    for (int i = 0; i < LANES; i++)
                    begin
                        src[i].data = pay_data[i*32+:32];
                        src[i].kp = 1'b1;
                        src[i].be = dword_be(q.idx + 11'(i), q.total, q.first_be, q.last_be,
                                             q.zero);
                    end
                    src[n-1].eof = 1'b1;
                    d.rem = q.rem - 11'(n);
                    d.idx = q.idx + 11'(n);
                    if (int'(q.rem) == n)
                    begin
                        d.st = S_PAD;
                    end
                end
            end
            S_PAD:
            begin
                if (room)
                begin
                    if (p != 0 && q.strad && p <= STRADDLE_LANE && hdr_valid)
                    begin
                        n = STRADDLE_LANE - p;
                    end
                    else
                    begin
                        n = (LANES - p) % LANES;
                    end
                    for (int i = 0; i < LANES; i++)
                    begin
                        src[i].kp = q.strad;
                    end
                    d.st = S_IDLE;
                end
            end
        endcase
        for (int i = 0; i < 2 * LANES; i++)
        begin
            if (i >= c1 && i < c1 + n)
            begin
                d.lanes[i] = src[i-c1];
            end
        end
        d.count = CW'(c1 + n);
        d.ack = wb_cyc_i && wb_stb_i && !q.ack;
        if (d.ack)
        begin
            d.rdata = 32'h0000_0000;
            if (wb_we_i && wb_adr_i == CTRL_OFFSET && wb_sel_i[0])
            begin
                d.ctrl_aligned = wb_dat_i[CTRL_ALIGNED_BIT];
                d.ctrl_strad = wb_dat_i[CTRL_STRADDLE_BIT];
            end
            if (!wb_we_i)
            begin
                unique case (wb_adr_i)
                    CTRL_OFFSET:
                    begin
                        d.rdata[CTRL_ALIGNED_BIT] = q.ctrl_aligned;
                        d.rdata[CTRL_STRADDLE_BIT] = q.ctrl_strad;
                    end
                    STATUS_OFFSET:
                    begin
                        d.rdata[STATUS_BUSY_BIT] = (q.st != S_IDLE) || (q.count != '0);
                        d.rdata[STATUS_COUNT_POS+:CW] = q.count;
                    end
                    DELIVERED_OFFSET:
                    begin
                        d.rdata = q.delivered;
                    end
                    default:
                    begin
                        d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.ctrl_aligned <= CTRL_ALIGNED_RESET;
            q.ctrl_strad <= CTRL_STRADDLE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------
    // stream outputs
    // ----------------------------------------
    always_comb
    begin
        logic [2:0] e0;
        logic [2:0] e1;
        int ne;
        logic any_sof;
        e0 = 3'h0;
        e1 = 3'h0;
        ne = 0;
        any_sof = 1'b0;
        wb_dat_o = q.rdata;
        wb_ack_o = q.ack;
        completion_stream_valid = int'(q.count) >= LANES;
        for (int i = 0; i < LANES; i++)
        begin
            completion_stream_data[i*32+:32] = q.lanes[i].data;
            completion_byte_enable[i*4+:4] = q.lanes[i].be;
            completion_dword_keep[i] = q.strad | q.lanes[i].kp;
            any_sof = any_sof | q.lanes[i].sof;
            if (q.lanes[i].eof)
            begin
                if (ne == 0)
                begin
                    e0 = 3'(i);
                end
                else
                begin
                    e1 = 3'(i);
                end
                ne = ne + 1;
            end
        end
        completion_packet_last = !q.strad && (ne != 0);
        first_packet_start_flag = any_sof;
        second_packet_start_flag = q.strad && q.lanes[0].sof
                                   && q.lanes[STRADDLE_LANE].sof;
        first_packet_end_field = {e0, ne != 0};
        second_packet_end_field = {e1, ne > 1};
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_stall_hold: assert property (
        completion_stream_valid && !completion_stream_accept |=>
        $stable(completion_stream_data) && $stable(completion_dword_keep)
        && $stable(completion_packet_last) && $stable(completion_byte_enable)
        && $stable(first_packet_end_field) && $stable(first_packet_start_flag)
        && $stable(second_packet_start_flag) && $stable(second_packet_end_field))
        else $error("stalled beat changed");
    a_valid_held: assert property (
        completion_stream_valid && !completion_stream_accept |=> completion_stream_valid)
        else $error("valid dropped before accept");
    a_last_end: assert property (
        completion_stream_valid && completion_stream_accept && !q.strad
        ##1 completion_stream_valid && !q.strad
        |-> first_packet_start_flag == $past(completion_packet_last))
        else $error("last not on final beat");
    a_straddle_keep: assert property (
        completion_stream_valid && q.strad |-> (&completion_dword_keep) && !completion_packet_last)
        else $error("straddle keep or last wrong");
    a_keep_final: assert property (
        completion_stream_valid && !q.strad && !completion_dword_keep[LANES-1]
        |-> completion_packet_last)
        else $error("keep hole outside final beat");
    a_second_start: assert property (
        second_packet_start_flag |-> first_packet_start_flag && first_packet_end_field[0]
        && first_packet_end_field[3:1] <= 3'h3)
        else $error("second start without first end");
    a_second_end: assert property (
        second_packet_end_field[0] |-> first_packet_end_field[0]
        && second_packet_end_field[3:1] inside {3'h6, 3'h7}
        && first_packet_end_field[3:1] <= 3'h3)
        else $error("second end offset wrong");
    a_desc_noen: assert property (
        completion_stream_valid && first_packet_start_flag && !q.strad
        |-> completion_byte_enable[11:0] == 12'h000)
        else $error("enable on descriptor lane");
    a_aligned_gap: assert property (
        completion_stream_valid && first_packet_start_flag && q.aligned
        |-> completion_byte_enable == '0)
        else $error("payload in descriptor beat");
    a_straddle_mode: assert property (
        completion_stream_valid && q.aligned |-> !second_packet_end_field[0])
        else $error("straddle with aligned mode");

endmodule

// >>> completion_stream_sink.sv
`timescale 1ns/1ns
module completion_stream_sink
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic completion_stream_valid,
    input wire logic [255:0] completion_stream_data,
    input wire logic [7:0] completion_dword_keep,
    input wire logic completion_packet_last,
    input wire logic [31:0] completion_byte_enable,
    input wire logic first_packet_start_flag,
    input wire logic second_packet_start_flag,
    input wire logic [3:0] first_packet_end_field,
    input wire logic [3:0] second_packet_end_field,
    output logic completion_stream_accept,
    output logic [7:0] hold_faults
);
    // ----------------------------------------
    // accept pacing and beat capture
    // ----------------------------------------
    logic [306:0] beats [$];
    logic [306:0] beat_now;
    logic [306:0] beat_prev = '0;
    logic pend = 1'b0;
    logic [1:0] phase = 2'h0;
    // second fields captured; hold check judges them always, beat checks only when straddling
    assign beat_now = {completion_stream_data, completion_byte_enable, completion_dword_keep,
        completion_packet_last, first_packet_start_flag, second_packet_start_flag,
        first_packet_end_field, second_packet_end_field};
    always @(posedge mclk)
    begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        // accept dropped two of three cycles when slow
        completion_stream_accept <= rst_b && (!slow || phase == 2'h1);
        if (!rst_b)
            hold_faults <= 8'h00;
        else if (pend && (completion_stream_valid !== 1'b1 || beat_now !== beat_prev))
            hold_faults <= hold_faults + 8'h01;
        pend <= rst_b && completion_stream_valid === 1'b1 && !completion_stream_accept;
        beat_prev <= beat_now;
        if (completion_stream_valid === 1'b1 && completion_stream_accept)
            beats.push_back(beat_now);
    end
endmodule

// >>> completion_stream_delivery_tb.sv
`timescale 1ns/1ns
module completion_stream_delivery_tb import completion_stream_pkg::*;;
    localparam logic [95:0] DA = 96'hD2D2D2D2_D1D1D1D1_D0D0D0D0;
    localparam logic [95:0] DB = 96'hE2E2E2E2_E1E1E1E1_E0E0E0E0;
    localparam logic [255:0] PAY = {32'hA7A7A7A7, 32'hA6A6A6A6, 32'hA5A5A5A5, 32'hA4A4A4A4,
        32'hA3A3A3A3, 32'hA2A2A2A2, 32'hA1A1A1A1, 32'hA0A0A0A0};
    localparam logic [306:0] M_NS = {{298{1'b1}}, 9'h000};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic hdr_valid = 1'b0;
    logic hdr_ready;
    logic [95:0] hdr_desc = 96'h0;
    logic [10:0] hdr_dword_count = 11'h000;
    logic [3:0] hdr_first_be = 4'h0;
    logic [3:0] hdr_last_be = 4'h0;
    logic [2:0] hdr_addr_offset = 3'h0;
    logic hdr_zero_len = 1'b0;
    logic pay_valid = 1'b0;
    logic pay_ready;
    logic slow = 1'b0;
    logic s_valid, s_accept, s_last, sof0, sof1;
    logic [255:0] s_data;
    logic [7:0] s_keep, hold_faults;
    logic [31:0] s_be, rd;
    logic [3:0] eof0, eof1;
    int errors = 0;
    int compares = 0;
    always #4 mclk = ~mclk;
    completion_stream_delivery #(.LANES(8)) DUT (.mclk(mclk), .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_desc(hdr_desc),
        .hdr_dword_count(hdr_dword_count), .hdr_first_be(hdr_first_be),
        .hdr_last_be(hdr_last_be), .hdr_addr_offset(hdr_addr_offset),
        .hdr_zero_len(hdr_zero_len), .pay_valid(pay_valid), .pay_ready(pay_ready),
        .pay_data(PAY), .completion_stream_valid(s_valid),
        .completion_stream_accept(s_accept), .completion_stream_data(s_data),
        .completion_dword_keep(s_keep), .completion_packet_last(s_last),
        .completion_byte_enable(s_be), .first_packet_start_flag(sof0),
        .second_packet_start_flag(sof1), .first_packet_end_field(eof0),
        .second_packet_end_field(eof1));
    completion_stream_sink sink (.mclk(mclk), .rst_b(rst_b), .slow(slow),
        .completion_stream_valid(s_valid), .completion_stream_data(s_data),
        .completion_dword_keep(s_keep), .completion_packet_last(s_last),
        .completion_byte_enable(s_be), .first_packet_start_flag(sof0),
        .second_packet_start_flag(sof1), .first_packet_end_field(eof0),
        .second_packet_end_field(eof1), .completion_stream_accept(s_accept),
        .hold_faults(hold_faults));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic late(input int n);
        if (n >= 300)
        begin
            errors++;
            $display("ERROR %0t: handshake timeout", $time);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_beat(input int i, input logic [306:0] exp, input logic [306:0] m);
        logic [306:0] got;
        got = (sink.beats.size() > i) ? sink.beats[i] : 'x;
        compares++;
        if ((got & m) !== (exp & m))
        begin
            errors++;
            $display("ERROR %0t: beat %0d got %h", $time, i, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge mclk); while (wb_ack_o !== 1'b1 && ++n < 300);
        late(n);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic pkt(input logic [95:0] d, input logic [10:0] c, input logic [3:0] f,
        input logic [3:0] l, input logic [2:0] o, input logic z);
        int n;
        n = 0;
        hdr_valid <= 1'b1;
        hdr_desc <= d;
        hdr_dword_count <= c;
        hdr_first_be <= f;
        hdr_last_be <= l;
        hdr_addr_offset <= o;
        hdr_zero_len <= z;
        do @(posedge mclk); while (hdr_ready !== 1'b1 && ++n < 300);
        late(n);
        hdr_valid <= 1'b0;
        if (c != 11'h000)
        begin
            n = 0;
            pay_valid <= 1'b1;
            do @(posedge mclk); while (pay_ready !== 1'b1 && ++n < 300);
            late(n);
            pay_valid <= 1'b0;
        end
    endtask
    task automatic beats(input int n);
        int k;
        k = 0;
        while (sink.beats.size() < n && k < 300)
        begin
            @(posedge mclk);
            k++;
        end
        late(k);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        wb(1'b0, CTRL_OFFSET, 32'h0);
        chk_word(rd, 32'h0);
        wb(1'b0, STATUS_OFFSET, 32'h0);
        chk_word(rd, 32'h0);
        wb(1'b0, 8'hFC, 32'h0);
        chk_word(rd, 32'h0);
        wb(1'b1, CTRL_OFFSET, 32'hFFFFFFFF);
        wb(1'b0, CTRL_OFFSET, 32'h0);
        chk_word(rd, 32'h3);
        wb(1'b1, CTRL_OFFSET, 32'h0);
    endtask
    task automatic t_dword();
        sink.beats.delete();
        slow <= 1'b1;
        pkt(DA, 11'd6, 4'hE, 4'h3, 3'h0, 1'b0);
        beats(2);
        chk_beat(0, {PAY[159:0], DA, 16'hFFFF, 4'hE, 12'h0, 8'hFF, 2'b01, 9'h0},
            M_NS);
        chk_beat(1, {224'h0, PAY[191:160], 28'h0, 4'h3, 8'h01, 2'b10, 9'h0},
            {224'h0, {74{1'b1}}, 9'h0});
        slow <= 1'b0;
    endtask
    task automatic t_aligned();
        wb(1'b1, CTRL_OFFSET, 32'h1);
        sink.beats.delete();
        pkt(DA, 11'd2, 4'h1, 4'h8, 3'h5, 1'b0);
        beats(2);
        chk_beat(0, {160'h0, DA, 32'h0, 8'hFF, 2'b01, 9'h0},
            {160'h0, {138{1'b1}}, 9'h0});
        chk_beat(1, {32'h0, PAY[63:0], 160'h0, 4'h0, 4'h8, 4'h1, 20'h0, 8'h7F, 2'b10, 9'h0},
            {32'h0, {64{1'b1}}, 160'h0, {42{1'b1}}, 9'h0});
        wb(1'b1, CTRL_OFFSET, 32'h0);
    endtask
    task automatic t_zero();
        sink.beats.delete();
        pkt(DA, 11'd1, 4'hF, 4'hF, 3'h0, 1'b1);
        beats(1);
        chk_beat(0, {128'h0, PAY[31:0], DA, 32'h0, 8'h0F, 2'b11, 9'h0},
            {128'h0, {170{1'b1}}, 9'h0});
    endtask
    task automatic t_straddle();
        wb(1'b1, CTRL_OFFSET, 32'h2);
        sink.beats.delete();
        slow <= 1'b1;
        pkt(DA, 11'd1, 4'hF, 4'hF, 3'h0, 1'b0);
        pkt(DB, 11'd0, 4'h0, 4'h0, 3'h0, 1'b0);
        beats(1);
        chk_beat(0, {32'h0, DB, PAY[31:0], DA, 32'h0000F000, 8'hFF, 3'b011, 4'h7, 4'hD},
            {32'h0, {275{1'b1}}});
        slow <= 1'b0;
        wb(1'b1, CTRL_OFFSET, 32'h0);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_dword();
        t_aligned();
        t_zero();
        t_straddle();
        chk_word({24'h0, hold_faults}, 32'h0);
        wb(1'b0, DELIVERED_OFFSET, 32'h0);
        chk_word(rd, 32'h5);
        wrap_up();
    end
    initial
    begin
        repeat (6000) @(posedge mclk);
        errors++;
        wrap_up();
    end
endmodule
